// ### logic/slp_driver.sv
// Application end of the shared panel: owns the panel on request and sends whole lines.
// Assumes an APB master on clk_sys; the link clock is made here by division.
//
// Contract
// - Select low: housekeeping side drives, application releases.
// - Select high: application drives; application sets select.
// - Panel takes data on clock only while selected.
// - Link clock stays at or below 1.1 MHz.
// - Only whole 128-bit lines are sent.
// - Image is 128 by 128 one-bit pixels.
// - Panel keeps written pixels without refresh.
// - Owner toggles polarity line periodically while used; the driver toggles it only while pol_en is also set, and pol_en resets to 0.
//
// The register addresses and register access over APB were decided locally.
`timescale 1ns/1ns
module slp_driver import slp_pkg::*; #(
  parameter int HALF_CYC     = `SLP_HALF_MIN,
  parameter int POL_HALF_CYC = `SLP_POL_HALF_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  slp_link_if.driver       link
);
  generate
    if (HALF_CYC < `SLP_HALF_MIN || HALF_CYC > 255) begin : g_chk_half
      $error("HALF_CYC would exceed the link clock limit or the counter");
    end
    if (POL_HALF_CYC < 1 || POL_HALF_CYC > 32'h00FFFFFF) begin : g_chk_pol
      $error("POL_HALF_CYC out of range");
    end
  endgenerate

  typedef struct packed {
    logic                own;
    logic                pol_en;
    logic                refused;
    slp_addr_t           line;
    slp_line_t           data;
    slp_tx_state_t       st;
    logic [7:0]          half;
    logic [7:0]          left;
    logic [`SLP_FRAME_BITS-1:0] tx;
    logic                sclk;
    logic                si;
    logic                cs;
    logic [23:0]         pol_cnt;
    logic                pol;
    logic [31:0]         rdata;
  } slp_drv_t;

  slp_drv_t s, next_s;
  logic     wr_en;
  logic     rd_en;
  logic     mapped;
  logic     half_end;

  // Reverses the line address so that it leaves MSB first from the LSB end.
  function automatic slp_addr_t rev_addr(input slp_addr_t a);
    slp_addr_t r;
    r = '0;
    for (int i = 0; i < `SLP_ADDR_BITS; i++) begin
      r[i] = a[`SLP_ADDR_BITS-1-i];
    end
    return r;
  endfunction

  // True for any offset this end answers.
  function automatic logic is_mapped(input logic [7:0] a);
    return (a == `SLP_REG_CTRL) || (a == `SLP_REG_LINE) || (a == `SLP_REG_CMD) ||
           (a == `SLP_REG_STATUS) || (a >= `SLP_REG_DATA0 && a <= `SLP_REG_DATA3);
  endfunction

  // Word index of a pixel data offset, kept two bits wide so the offset cannot wrap past the line.
  function automatic logic [1:0] data_word(input logic [7:0] a);
    return 2'(a[3:2] - 2'h2);
  endfunction

  // Zero-wait APB slave: every access completes in its first access cycle.
  assign mapped   = is_mapped(paddr);
  assign wr_en    = psel & penable & pwrite & mapped;
  assign rd_en    = psel & ~penable & ~pwrite & mapped;
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~mapped;
  assign half_end = (s.half == 8'(HALF_CYC - 1));

  always_comb begin
    next_s = s;
    // Register writes; ownership and line contents are frozen while a line is sent.
    if (wr_en) begin
      case (paddr)
        `SLP_REG_CTRL: begin
          if (s.st == SLP_IDLE) begin
            next_s.own = pwdata[`SLP_CTRL_OWN];
          end
          next_s.pol_en = pwdata[`SLP_CTRL_POLEN];
        end
        `SLP_REG_LINE: begin
          if (s.st == SLP_IDLE) begin
            next_s.line = pwdata[`SLP_ADDR_BITS-1:0];
          end
        end
        `SLP_REG_CMD: begin
          if (pwdata[`SLP_CMD_START]) begin
            if (s.st == SLP_IDLE && s.own) begin
              next_s.st   = SLP_LOW;
              next_s.tx   = {s.data, rev_addr(s.line)};
              next_s.left = 8'(`SLP_FRAME_BITS);
              next_s.half = '0;
              next_s.cs   = 1'b1;
              next_s.si   = s.line[`SLP_ADDR_BITS-1];
            end else begin
              next_s.refused = 1'b1;
            end
          end
        end
        `SLP_REG_STATUS: begin
          next_s.refused = 1'b0;
        end
        default: begin
          if (s.st == SLP_IDLE) begin
            next_s.data[{data_word(paddr), 5'h00} +: 32] = pwdata;
          end
        end
      endcase
    end
    // Read data is captured in the setup cycle so the access phase sees a flop.
    if (rd_en) begin
      case (paddr)
        `SLP_REG_CTRL:   next_s.rdata = {30'h0, s.pol_en, s.own};
        `SLP_REG_LINE:   next_s.rdata = {25'h0, s.line};
        `SLP_REG_CMD:    next_s.rdata = 32'h0000_0000;
        `SLP_REG_STATUS: next_s.rdata = {29'h0, s.refused, s.own, s.st != SLP_IDLE};
        default:         next_s.rdata = s.data[{data_word(paddr), 5'h00} +: 32];
      endcase
    end
    // Link sequencer: data set up in the low half, panel samples on the rising edge.
    next_s.half = half_end ? 8'h00 : s.half + 8'h01;
    case (s.st)
      SLP_IDLE: begin
        next_s.half = '0;
      end
      SLP_LOW: begin
        if (half_end) begin
          next_s.sclk = 1'b1;
          next_s.st   = SLP_HIGH;
          next_s.left = s.left - 8'h01;
        end
      end
      SLP_HIGH: begin
        if (half_end) begin
          next_s.sclk = 1'b0;
          next_s.tx   = {1'b0, s.tx[`SLP_FRAME_BITS-1:1]};
          next_s.si   = s.tx[1];
          next_s.st   = (s.left == 8'h00) ? SLP_TAIL : SLP_LOW;
        end
      end
      SLP_TAIL: begin
        if (half_end) begin
          next_s.cs = 1'b0;
          next_s.si = 1'b0;
          next_s.st = SLP_IDLE;
        end
      end
      default: begin
        next_s.st = SLP_IDLE;
      end
    endcase
    // Polarity line toggles at a fixed rate while owned and enabled.
    if (s.own && s.pol_en) begin
      if (s.pol_cnt == 24'(POL_HALF_CYC - 1)) begin
        next_s.pol_cnt = '0;
        next_s.pol     = ~s.pol;
      end else begin
        next_s.pol_cnt = s.pol_cnt + 24'h1;
      end
    end else begin
      next_s.pol_cnt = '0;
      next_s.pol     = 1'b0;
    end
  end

  // Single state register.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s        <= '0;
      s.own    <= 1'(`SLP_CTRL_RST >> `SLP_CTRL_OWN);
      s.pol_en <= 1'b0;
      s.st     <= SLP_IDLE;
    end else begin
      s <= next_s;
    end
  end

  // The select always reflects the owner; panel pins are driven only while owning.
  assign link.panel_owner_select       = s.own;
  assign link.panel_serial_clock_o     = s.sclk;
  assign link.panel_serial_in_o        = s.si;
  assign link.panel_chip_select_o      = s.cs;
  assign link.panel_polarity_toggle_o  = s.pol;
  assign link.panel_serial_clock_oe    = s.own;
  assign link.panel_serial_in_oe       = s.own;
  assign link.panel_chip_select_oe     = s.own;
  assign link.panel_polarity_toggle_oe = s.own;
  assign prdata                        = s.rdata;
endmodule

// ### logic/slp_map.svh
// Constants of the shared panel line port: register offsets, fields, resets and timing.
// Assumes inclusion by bare name from the package only.
`ifndef SLP_MAP_SVH
`define SLP_MAP_SVH
// Panel geometry.
`define SLP_LINE_BITS   128
`define SLP_LINES       128
`define SLP_ADDR_BITS   7
// Frame length: line address first, then the pixels of the line.
`define SLP_FRAME_BITS  135
// Timing: system rate and the fastest link clock the panel accepts.
`define SLP_SYS_HZ      20000000
`define SLP_LINK_MAX_HZ 1100000
// Least half period of the link clock, rounded up to whole system cycles.
`define SLP_HALF_MIN    ((`SLP_SYS_HZ + 2 * `SLP_LINK_MAX_HZ - 1) / (2 * `SLP_LINK_MAX_HZ))
// Half period of the polarity toggle in milliseconds, and in system cycles.
`define SLP_POL_HALF_MS 500
`define SLP_POL_HALF_CYC (`SLP_SYS_HZ / 1000 * `SLP_POL_HALF_MS)
// Device watchdog on the polarity line, in milliseconds and system cycles.
`define SLP_POL_WDOG_MS  2000
`define SLP_POL_WDOG_CYC (`SLP_SYS_HZ / 1000 * `SLP_POL_WDOG_MS)
// Register offsets of the driver end.
`define SLP_REG_CTRL    8'h00
`define SLP_REG_LINE    8'h04
`define SLP_REG_DATA0   8'h08
`define SLP_REG_DATA3   8'h14
`define SLP_REG_CMD     8'h18
`define SLP_REG_STATUS  8'h1C
// Field positions.
`define SLP_CTRL_OWN    0
`define SLP_CTRL_POLEN  1
`define SLP_CMD_START   0
`define SLP_STAT_BUSY   0
`define SLP_STAT_OWN    1
`define SLP_STAT_REFUSE 2
// Reset values.
`define SLP_CTRL_RST    2'h0
`endif

// ### logic/slp_pkg.sv
// Types shared by both ends of the shared panel line port.
// Assumes slp_map.svh on the include path.
package slp_pkg;
  `include "slp_map.svh"
  typedef logic [`SLP_LINE_BITS-1:0] slp_line_t;
  typedef logic [`SLP_ADDR_BITS-1:0] slp_addr_t;
  typedef enum logic [1:0] {SLP_IDLE, SLP_LOW, SLP_HIGH, SLP_TAIL} slp_tx_state_t;
endpackage

// ### logic/slp_link_if.sv
// Link between the panel driver end and the panel end.
// Assumes an undriven panel input reads low, as with a pull-down on the board.
`timescale 1ns/1ns
interface slp_link_if;
  logic panel_owner_select;
  logic panel_serial_clock_o;
  logic panel_serial_clock_oe;
  logic panel_serial_in_o;
  logic panel_serial_in_oe;
  logic panel_chip_select_o;
  logic panel_chip_select_oe;
  logic panel_polarity_toggle_o;
  logic panel_polarity_toggle_oe;
  logic panel_serial_clock;
  logic panel_serial_in;
  logic panel_chip_select;
  logic panel_polarity_toggle;
  // Level seen by the panel: the enabled driver, else the pull-down.
  assign panel_serial_clock    = panel_serial_clock_oe & panel_serial_clock_o;
  assign panel_serial_in       = panel_serial_in_oe & panel_serial_in_o;
  assign panel_chip_select     = panel_chip_select_oe & panel_chip_select_o;
  assign panel_polarity_toggle = panel_polarity_toggle_oe & panel_polarity_toggle_o;
  modport driver (
    output panel_owner_select, panel_serial_clock_o, panel_serial_clock_oe, panel_serial_in_o,
           panel_serial_in_oe, panel_chip_select_o, panel_chip_select_oe, panel_polarity_toggle_o,
           panel_polarity_toggle_oe
  );
  modport panel (
    input panel_owner_select, panel_serial_clock, panel_serial_in, panel_chip_select,
          panel_polarity_toggle
  );
endinterface

// ### logic/slp_panel.sv
// Panel end: 128 lines of 128 one-bit pixels written a line at a time over the link.
// Assumes the link clock idles low and the chip select is low between frames.
`timescale 1ns/1ns
module slp_panel import slp_pkg::*; #(
  parameter int POL_WDOG_CYC = `SLP_POL_WDOG_CYC
) (
  input  wire logic      clk_sys,
  input  wire logic      arst_n,
  slp_link_if.panel      link,
  input  wire slp_addr_t rd_line,
  output slp_line_t      rd_pixels,
  output logic           line_done,
  output slp_addr_t      last_line,
  output logic           app_owns,
  output logic           polarity_stale
);
  generate
    if (POL_WDOG_CYC < 2 || POL_WDOG_CYC > 32'h3FFFFFFF) begin : g_chk
      $error("POL_WDOG_CYC out of range");
    end
  endgenerate

  // Frame state on the link clock, cleared whenever the chip select is low.
  typedef struct packed {
    logic [7:0] cnt;
    slp_addr_t  addr;
    slp_line_t  data;
  } slp_frame_t;
  // Commit event and line number, kept across frames.
  typedef struct packed {
    logic      tgl;
    slp_addr_t line;
  } slp_commit_t;
  // System side state.
  typedef struct packed {
    logic [2:0]  tgl_sync;
    logic [2:0]  pol_sync;
    logic [1:0]  own_sync;
    logic [29:0] pol_age;
    logic        stale;
    logic        done;
    slp_addr_t   line;
    slp_line_t   rd;
  } slp_sys_t;

  slp_frame_t  fr, next_fr;
  slp_commit_t cm, next_cm;
  slp_sys_t    ss, next_ss;
  slp_line_t   mem [`SLP_LINES];
  logic        frame_rst_n;
  logic        commit;

  // The frame ends with its own select: a low select holds the shifter cleared.
  assign frame_rst_n = arst_n & link.panel_chip_select;
  // The last data bit of a whole line writes the line; shorter frames are dropped.
  assign commit = (fr.cnt == 8'(`SLP_FRAME_BITS - 1));

  // Shifts address bits MSB first, then pixels with the first pixel at bit 0.
  always_comb begin
    next_fr = fr;
    if (fr.cnt < 8'(`SLP_ADDR_BITS)) begin
      next_fr.addr = {fr.addr[`SLP_ADDR_BITS-2:0], link.panel_serial_in};
    end else begin
      next_fr.data = {link.panel_serial_in, fr.data[`SLP_LINE_BITS-1:1]};
    end
    next_fr.cnt = commit ? 8'h00 : fr.cnt + 8'h01;
    next_cm = cm;
    if (commit) begin
      next_cm.tgl  = ~cm.tgl;
      next_cm.line = fr.addr;
    end
  end

  // Samples on the rising link clock only while selected.
  always_ff @(posedge link.panel_serial_clock or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      fr <= '0;
    end else begin
      fr <= next_fr;
    end
  end

  // Keeps the commit toggle through deselection.
  always_ff @(posedge link.panel_serial_clock or negedge arst_n) begin
    if (!arst_n) begin
      cm <= '0;
    end else begin
      cm <= next_cm;
    end
  end

  // Pixel store: one bit per pixel, held until the line is written again.
  always_ff @(posedge link.panel_serial_clock) begin
    if (link.panel_chip_select && commit) begin
      mem[fr.addr] <= {link.panel_serial_in, fr.data[`SLP_LINE_BITS-1:1]};
    end
  end

  // Synchronises link levels, reports commits and watches the polarity line.
  always_comb begin
    next_ss          = ss;
    next_ss.tgl_sync = {ss.tgl_sync[1:0], cm.tgl};
    next_ss.pol_sync = {ss.pol_sync[1:0], link.panel_polarity_toggle};
    next_ss.own_sync = {ss.own_sync[0], link.panel_owner_select};
    next_ss.done     = ss.tgl_sync[2] ^ ss.tgl_sync[1];
    if (ss.tgl_sync[2] ^ ss.tgl_sync[1]) begin
      next_ss.line = cm.line;
    end
    // Stale once the polarity line has not moved for the watchdog time.
    if (ss.pol_sync[2] ^ ss.pol_sync[1]) begin
      next_ss.pol_age = '0;
      next_ss.stale   = 1'b0;
    end else if (ss.pol_age == 30'(POL_WDOG_CYC - 1)) begin
      next_ss.stale = 1'b1;
    end else begin
      next_ss.pol_age = ss.pol_age + 30'h1;
    end
    next_ss.rd = mem[rd_line];
  end

  // System side register.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ss <= '0;
    end else begin
      ss <= next_ss;
    end
  end

  assign rd_pixels      = ss.rd;
  assign line_done      = ss.done;
  assign last_line      = ss.line;
  assign app_owns       = ss.own_sync[1];
  assign polarity_stale = ss.stale;
endmodule

// ### tb/slp_link_sva.sv
// Checker of the link between the panel driver end and the panel end.
// Assumes the resolved and enable signals of one link, sampled on clk_sys.
`timescale 1ns/1ns
module slp_link_sva #(
  parameter int POL_HALF_CYC = 50
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic panel_owner_select,
  input wire logic panel_serial_clock_oe,
  input wire logic panel_serial_in_oe,
  input wire logic panel_chip_select_oe,
  input wire logic panel_polarity_toggle_oe,
  input wire logic panel_serial_clock,
  input wire logic panel_serial_in,
  input wire logic panel_chip_select,
  input wire logic panel_polarity_toggle
);
  logic [7:0]  rises;
  logic [11:0] frame_len;
  logic        sclk_q;
  // Counts rising link clock edges and system cycles inside the current frame.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rises     <= 8'h00;
      frame_len <= 12'h000;
      sclk_q    <= 1'b0;
    end else begin
      sclk_q <= panel_serial_clock;
      if (!panel_chip_select) begin
        rises     <= 8'h00;
        frame_len <= 12'h000;
      end else begin
        if (panel_serial_clock && !sclk_q) begin
          rises <= rises + 8'h01;
        end
        // Saturates so a stuck select cannot wrap back into the legal range.
        if (frame_len != 12'hFFF) begin
          frame_len <= frame_len + 12'h001;
        end
      end
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);
  // Named steps of a frame and of a toggle phase.
  sequence s_clk_held;
    $stable(panel_serial_clock)[*8];
  endsequence
  sequence s_pol_high;
    panel_polarity_toggle[*8];
  endsequence
  a_release_when_low: assert property (!panel_owner_select |->
    !(panel_serial_clock_oe | panel_serial_in_oe | panel_chip_select_oe | panel_polarity_toggle_oe))
    else $error("pins driven without ownership");
  a_drive_when_high: assert property (panel_owner_select |->
    (panel_serial_clock_oe & panel_serial_in_oe & panel_chip_select_oe & panel_polarity_toggle_oe))
    else $error("owner leaves pins undriven");
  // A phase of at least ten system cycles keeps the link clock at or below its limit.
  a_clock_rate_limit: assert property ($changed(panel_serial_clock) |=>
    s_clk_held ##1 $stable(panel_serial_clock)) else $error("link clock phase too short");
  a_clock_in_frame: assert property (panel_serial_clock |-> panel_chip_select)
    else $error("link clock outside frame");
  a_data_held_high: assert property ($rose(panel_serial_clock) |-> $stable(panel_serial_in)[*8])
    else $error("data moved while clock high");
  a_frame_bit_count: assert property ($fell(panel_chip_select) |-> rises == 8'h87)
    else $error("frame is not 135 bits");
  // A whole frame keeps the select high for 2600 to 2800 system cycles.
  a_frame_time_bound: assert property ($fell(panel_chip_select) |->
    frame_len >= 12'hA28 && frame_len <= 12'hAF0) else $error("frame length out of range");
  a_frame_not_stuck: assert property (panel_chip_select |-> frame_len <= 12'hAF0)
    else $error("frame never ends");
  a_polarity_half_period: assert property ($rose(panel_polarity_toggle) |-> s_pol_high
    ##[1:POL_HALF_CYC] !panel_polarity_toggle) else $error("polarity stuck high");
  a_isolate_other_side: assert property (!panel_owner_select |->
    !(panel_serial_clock | panel_serial_in | panel_chip_select | panel_polarity_toggle))
    else $error("released pins not low");
endmodule

// ### tb/test_shared_mono_lcd_line_port.sv
// Self-checking bench: driver end and panel end joined by one link.
// Assumes the design files compiled first; APB master runs on clk_sys.
`timescale 1ns/1ns
module test_shared_mono_lcd_line_port import slp_pkg::*;;
  localparam int POL_HALF = 50;
  localparam slp_line_t PA = 128'h8000_0001_F00F_1234_5678_9ABC_0000_0003;
  logic        clk_sys;
  logic        arst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  slp_addr_t   rd_line;
  slp_line_t   rd_pixels;
  logic        line_done;
  slp_addr_t   last_line;
  logic        app_owns;
  logic        polarity_stale;
  logic [31:0] rdata;
  logic        serr;
  int          err_count;
  int          comparisons;
  slp_link_if lnk();
  slp_driver #(.HALF_CYC(10), .POL_HALF_CYC(POL_HALF)) u_slp_driver (.clk_sys(clk_sys), .arst_n(arst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(lnk));
  slp_panel #(.POL_WDOG_CYC(200)) u_slp_panel (.clk_sys(clk_sys), .arst_n(arst_n), .link(lnk),
    .rd_line(rd_line), .rd_pixels(rd_pixels), .line_done(line_done), .last_line(last_line),
    .app_owns(app_owns), .polarity_stale(polarity_stale));
  slp_link_sva #(.POL_HALF_CYC(POL_HALF)) u_slp_link_sva (.clk_sys(clk_sys), .arst_n(arst_n),
    .panel_owner_select(lnk.panel_owner_select), .panel_serial_clock_oe(lnk.panel_serial_clock_oe),
    .panel_serial_in_oe(lnk.panel_serial_in_oe), .panel_chip_select_oe(lnk.panel_chip_select_oe),
    .panel_polarity_toggle_oe(lnk.panel_polarity_toggle_oe), .panel_serial_clock(lnk.panel_serial_clock),
    .panel_serial_in(lnk.panel_serial_in), .panel_chip_select(lnk.panel_chip_select),
    .panel_polarity_toggle(lnk.panel_polarity_toggle));
  // System clock of 50 ns.
  always #25 clk_sys = ~clk_sys;
  // Prints the counts and the verdict, then ends the run.
  task automatic close_out;
    $display("mismatches %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Compares a value with its expectation.
  task automatic chk(input logic [127:0] got, input logic [127:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask
  // A wait that ran out counts as a mismatch and ends the run.
  task automatic hang(input string what);
    err_count++;
    $display("unexpected at %0t: timeout %s", $time, what);
    close_out();
  endtask
  // One APB transfer; read data and error are taken at the completing edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
      if (n > 20) hang("apb");
    end while (pready !== 1'b1);
    rdata = prdata;
    serr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  // Loads a line number and its pixels.
  task automatic load(input slp_addr_t ln, input slp_line_t px);
    apb(1'b1, `SLP_REG_LINE, {25'h0, ln});
    for (int k = 0; k < 4; k++)
      apb(1'b1, `SLP_REG_DATA0 + 8'(4 * k), px[32 * k +: 32]);
  endtask
  // Waits for the panel to commit a line.
  task automatic wait_done;
    for (int n = 0; line_done !== 1'b1; n++) begin
      if (n > 4000) hang("line");
      @(posedge clk_sys);
    end
  endtask
  // Polls the status word until the sender has left its tail and takes writes again.
  task automatic wait_idle;
    for (int n = 0; n < 100; n++) begin
      apb(1'b0, `SLP_REG_STATUS, 32'h0);
      if (rdata[`SLP_STAT_BUSY] === 1'b0) begin
        return;
      end
    end
    hang("idle");
  endtask
  // Sends one line, checks the reported number and waits until the sender is free.
  task automatic send(input slp_addr_t ln, input slp_line_t px);
    load(ln, px);
    apb(1'b1, `SLP_REG_CMD, 32'h1);
    wait_done();
    chk(last_line, ln, "line number");
    wait_idle();
  endtask
  task automatic look(input slp_addr_t ln, input slp_line_t px);
    rd_line <= ln;
    repeat (3) @(posedge clk_sys);
    chk(rd_pixels, px, "stored pixels");
  endtask
  task automatic t_reset;
    chk({lnk.panel_owner_select, lnk.panel_chip_select, lnk.panel_serial_clock}, 3'h0, "idle link");
    apb(1'b0, `SLP_REG_CTRL, 32'h0);
    chk(rdata, 32'h0, "control reset");
    apb(1'b0, 8'h40, 32'h0);
    chk(serr, 1'b1, "unmapped address");
  endtask
  task automatic t_refuse;
    load(7'h11, PA);
    apb(1'b0, `SLP_REG_LINE, 32'h0);
    chk(rdata, 32'h11, "line number readback");
    apb(1'b0, `SLP_REG_DATA3, 32'h0);
    chk(rdata, PA[127:96], "last pixel word readback");
    apb(1'b1, `SLP_REG_CMD, 32'h1);
    chk(lnk.panel_chip_select, 1'b0, "frame without owner");
    apb(1'b0, `SLP_REG_STATUS, 32'h0);
    chk(rdata[2:0], 3'h4, "start refused");
    apb(1'b1, `SLP_REG_STATUS, 32'h0);
    apb(1'b0, `SLP_REG_STATUS, 32'h0);
    chk(rdata[2:0], 3'h0, "refusal cleared");
  endtask
  task automatic t_lines;
    apb(1'b1, `SLP_REG_CTRL, 32'h1);
    // The owner level reaches the panel's status through two synchroniser flops.
    repeat (2) @(posedge clk_sys);
    chk(app_owns, 1'b1, "panel sees owner");
    send(7'h00, PA);
    send(7'h7F, ~PA);
    look(7'h00, PA);
    look(7'h7F, ~PA);
  endtask
  task automatic t_busy;
    load(7'h40, {PA[63:0], ~PA[63:0]});
    apb(1'b1, `SLP_REG_CMD, 32'h1);
    apb(1'b1, `SLP_REG_LINE, 32'h41);
    apb(1'b1, `SLP_REG_CMD, 32'h1);
    apb(1'b0, `SLP_REG_STATUS, 32'h0);
    chk(rdata[2:0], 3'h7, "busy start refused");
    wait_done();
    chk(last_line, 7'h40, "line kept while busy");
    look(7'h40, {PA[63:0], ~PA[63:0]});
    wait_idle();
  endtask
  task automatic t_pol;
    int n;
    apb(1'b1, `SLP_REG_CTRL, 32'h3);
    for (n = 0; lnk.panel_polarity_toggle !== 1'b1; n++) begin
      if (n > 200) hang("toggle");
      @(posedge clk_sys);
    end
    for (n = 0; lnk.panel_polarity_toggle === 1'b1 && n < 200; n++)
      @(posedge clk_sys);
    chk(n, POL_HALF, "toggle half period");
    repeat (300) @(posedge clk_sys);
    chk(polarity_stale, 1'b0, "toggle seen");
    apb(1'b1, `SLP_REG_CTRL, 32'h0);
    chk({lnk.panel_owner_select, lnk.panel_polarity_toggle, lnk.panel_chip_select}, 3'h0, "released");
    // The release also takes two synchroniser flops to reach the panel's status.
    repeat (2) @(posedge clk_sys);
    chk(app_owns, 1'b0, "panel sees release");
    repeat (300) @(posedge clk_sys);
    chk(polarity_stale, 1'b1, "missing toggle flagged");
  endtask
  // Main sequence: reset for 16 cycles, then the scenarios.
  initial begin
    clk_sys     = 1'b0;
    arst_n      = 1'b0;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = 8'h00;
    pwdata      = 32'h0;
    rd_line     = 7'h00;
    err_count   = 0;
    comparisons = 0;
    repeat (16) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    t_reset();
    t_refuse();
    t_lines();
    t_busy();
    t_pol();
    close_out();
  end
endmodule
